// ---- rtl/ssc_core.sv ----
// Configuration register core behind the serial control port.
`timescale 1ns/1ps
module ssc_core
  import ssc_pkg::*;
#(
  // Identifier value is arbitrary.
  parameter logic [7:0] P_PART_ID = 8'h5a
)
(
  input  wire logic                    i_ref_clk,    // System clock, 50 MHz.
  input  wire logic                    i_rst_n,      // Asynchronous reset, active low.
  input  wire logic                    i_sclk,       // Serial clock pin.
  input  wire logic                    i_cs_n,       // Chip select pin, active low.
  input  wire logic                    i_sdi,        // Serial data in pin.
  output logic                         o_sdo,        // Serial data out.
  output logic                         o_sdo_oe,     // High while serial data out is driven.
  output logic                         o_lsb_first,  // Current shift order, high for LSB first.
  output logic                         o_soft_reset, // One-cycle soft reset pulse.
  output logic [CFG_COUNT*8-1:0]       o_active_cfg  // Active copies of buffered registers.
);

  ssc_if bus ();

  ssc_link u_link (
    .i_ref_clk (i_ref_clk),
    .i_rst_n   (i_rst_n),
    .i_sclk    (i_sclk),
    .i_cs_n    (i_cs_n),
    .i_sdi     (i_sdi),
    .o_sdo     (o_sdo),
    .o_sdo_oe  (o_sdo_oe),
    .bus       (bus.link)
  );

  ssc_state_t             state;
  logic [7:0]             first_byte;
  logic                   is_read;
  logic                   stream;
  logic [1:0]             bytes_left;
  logic [ADDR_W-1:0]      addr;
  logic                   commit_pend;
  logic [7:0]             master [CFG_COUNT];
  logic [7:0]             active [CFG_COUNT];
  logic [CFG_COUNT*8-1:0] master_flat;
  logic [CFG_COUNT*8-1:0] default_flat;
  logic [15:0]            inst;
  logic [ADDR_W-1:0]      inst_addr;
  logic [ADDR_W-1:0]      next_addr;
  logic                   inst_done;
  logic                   wr_en;
  logic                   cfg_wr;
  logic [CFG_IDX_W-1:0]   cfg_idx;
  logic                   commit_set;
  logic                   rst_req;
  logic [7:0]             port_value;

  assign bus.lsb_first = o_lsb_first;
  assign inst      = o_lsb_first ? {bus.rx_byte, first_byte} : {first_byte, bus.rx_byte};
  assign inst_addr = inst[ADDR_W-1:0];
  assign inst_done = bus.rx_valid && (state == ST_INSTR_LO);
  // Addresses run downward in MSB-first mode and upward in LSB-first mode.
  assign next_addr = o_lsb_first ? addr + 13'h0001 : addr - 13'h0001;
  assign wr_en     = bus.rx_valid && (state == ST_DATA) && !is_read;
  assign cfg_wr    = wr_en && (addr >= ADDR_CFG_FIRST) && (addr <= ADDR_CFG_LAST);
  assign cfg_idx   = CFG_IDX_W'(addr - ADDR_CFG_FIRST);
  assign commit_set = wr_en && (addr == ADDR_COMMIT) && bus.rx_byte[BIT_COMMIT];
  assign rst_req   = wr_en && (addr == ADDR_PORT_SETUP)
                     && (bus.rx_byte[BIT_RST_HI] || bus.rx_byte[BIT_RST_LO]);
  // Soft reset bits are self-clearing, so they always read back as zero.
  assign port_value = o_lsb_first ? (PORT_SETUP_RESET | PORT_LSB_MASK) : PORT_SETUP_RESET;

  function automatic logic [7:0] reg_read(input logic [ADDR_W-1:0] a);
    logic [CFG_IDX_W-1:0] idx;
    idx = CFG_IDX_W'(a - ADDR_CFG_FIRST);
    if (a == ADDR_PORT_SETUP)
      reg_read = port_value;
    else if (a == ADDR_PART_ID)
      reg_read = P_PART_ID;
    else if (a == ADDR_COMMIT)
      reg_read = {7'h00, commit_pend};
    else if ((a >= ADDR_CFG_FIRST) && (a <= ADDR_CFG_LAST))
      reg_read = master[idx];
    else
      reg_read = 8'h00;
  endfunction

  // Frame sequencing. Chip select may rise between bytes of a short transfer without
  // losing the frame; rising mid-byte, or at the end of a stream, restarts it.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state      <= ST_INSTR_HI;
      first_byte <= 8'h00;
      is_read    <= 1'b0;
      stream     <= 1'b0;
      bytes_left <= 2'h0;
      addr       <= 13'h0000;
      bus.sdo_en <= 1'b0;
    end
    else if (bus.frame_abort || (bus.frame_end && stream))
    begin
      state      <= ST_INSTR_HI;
      stream     <= 1'b0;
      bus.sdo_en <= 1'b0;
    end
    else if (bus.rx_valid)
    begin
      case (state)
        ST_INSTR_HI:
        begin
          first_byte <= bus.rx_byte;
          state      <= ST_INSTR_LO;
        end
        ST_INSTR_LO:
        begin
          is_read    <= inst[INST_RW_BIT];
          stream     <= (inst[INST_W_HI:INST_W_LO] == W_STREAM);
          bytes_left <= inst[INST_W_HI:INST_W_LO];
          addr       <= inst_addr;
          bus.sdo_en <= inst[INST_RW_BIT];
          state      <= ST_DATA;
        end
        ST_DATA:
        begin
          addr <= next_addr;
          if (!stream && (bytes_left == 2'h0))
          begin
            state      <= ST_INSTR_HI;
            bus.sdo_en <= 1'b0;
          end
          else if (!stream)
          begin
            bytes_left <= bytes_left - 2'h1;
          end
        end
        default:
        begin
          state <= ST_INSTR_HI;
        end
      endcase
    end
  end

  // Read data is fetched one byte ahead, as soon as the previous byte has been taken.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bus.tx_load <= 1'b0;
      bus.tx_byte <= 8'h00;
    end
    else
    begin
      bus.tx_load <= 1'b0;
      if (inst_done && inst[INST_RW_BIT])
      begin
        bus.tx_load <= 1'b1;
        bus.tx_byte <= reg_read(inst_addr);
      end
      else if (bus.rx_valid && (state == ST_DATA) && is_read
               && (stream || (bytes_left != 2'h0)))
      begin
        bus.tx_load <= 1'b1;
        bus.tx_byte <= reg_read(next_addr);
      end
    end
  end

  // Port setup register: only the bit-order bits are stored, the fixed bits are constant.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      o_lsb_first  <= 1'b0;
      o_soft_reset <= 1'b0;
    end
    else
    begin
      o_soft_reset <= rst_req;
      if (o_soft_reset)
        o_lsb_first <= 1'b0;
      else if (wr_en && (addr == ADDR_PORT_SETUP))
        o_lsb_first <= bus.rx_byte[BIT_LSB_HI] || bus.rx_byte[BIT_LSB_LO];
    end
  end

  // A new commit request wins over the clear that ends the previous copy.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
      commit_pend <= COMMIT_RESET;
    else if (o_soft_reset)
      commit_pend <= COMMIT_RESET;
    else
      commit_pend <= commit_set;
  end

  for (genvar g = 0; g < CFG_COUNT; g++)
  begin : g_cfg
    always_ff @(posedge i_ref_clk or negedge i_rst_n)
    begin
      if (!i_rst_n)
      begin
        master[g] <= CFG_RESET[g];
        active[g] <= CFG_RESET[g];
      end
      else if (o_soft_reset)
      begin
        master[g] <= CFG_RESET[g];
        active[g] <= CFG_RESET[g];
      end
      else
      begin
        if (cfg_wr && (cfg_idx == CFG_IDX_W'(g)))
          master[g] <= bus.rx_byte;
        if (commit_pend)
          active[g] <= master[g];
      end
    end
    assign o_active_cfg[g*8 +: 8] = active[g];
    assign master_flat[g*8 +: 8]  = master[g];
    assign default_flat[g*8 +: 8] = CFG_RESET[g];
  end

  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_rst_n);

  sequence commit_wr_s;
    commit_set && !rst_req;
  endsequence

  sequence setup_rst_s;
    rst_req;
  endsequence

  commit_copy_a: assert property (commit_pend && !o_soft_reset |=>
    o_active_cfg == $past(master_flat))
    else $error("Active copies do not match master after commit.");

  commit_self_clear_a: assert property (commit_wr_s |=> commit_pend ##1
    (!commit_pend || $past(commit_set)))
    else $error("Commit bit did not clear after the copy.");

  active_hold_a: assert property (!commit_pend && !o_soft_reset |=>
    $stable(o_active_cfg))
    else $error("Active copies changed without a commit.");

  fixed_bits_a: assert property ((reg_read(ADDR_PORT_SETUP) & PORT_FIXED_MASK)
    == PORT_FIXED_VAL)
    else $error("Port setup fixed bits read wrong.");

  lsb_follow_a: assert property (wr_en && (addr == ADDR_PORT_SETUP) && !rst_req
    |=> o_lsb_first == $past(bus.rx_byte[BIT_LSB_HI] || bus.rx_byte[BIT_LSB_LO]))
    else $error("Bit order does not follow the setup write.");

  soft_rst_a: assert property (setup_rst_s |=> o_soft_reset ##1
    (!o_lsb_first && (master_flat == default_flat) && !commit_pend))
    else $error("Soft reset did not restore defaults.");

  id_ro_a: assert property (inst_done && inst[INST_RW_BIT]
    && (inst_addr == ADDR_PART_ID) |=> bus.tx_load && (bus.tx_byte == P_PART_ID))
    else $error("Identifier read returned a wrong value.");

  abort_idle_a: assert property (bus.frame_abort |=>
    (state == ST_INSTR_HI) && !bus.sdo_en ##1 !o_sdo_oe)
    else $error("Aborted frame did not return to idle.");

endmodule

// ---- rtl/ssc_pkg.sv ----
// Constants, field positions and types shared by the serial configuration register core.
//
// Overview of operation
// - Reset loads every register with its default.
// - Undefined bits are ignored and do nothing.
// - Bit-order bits set select LSB-first shifting.
// - Soft reset bits trigger a device soft reset.
// - Identifier address returns fixed read-only code.
// - Buffered registers change only after a commit or a soft reset.
// - Port shifts MSB first after power-up.
package ssc_pkg;

  localparam int          ADDR_W          = 13;
  localparam logic [12:0] ADDR_PORT_SETUP = 13'h0000;
  localparam logic [12:0] ADDR_PART_ID    = 13'h0001;
  localparam logic [12:0] ADDR_CFG_FIRST  = 13'h0008;
  localparam logic [12:0] ADDR_CFG_LAST   = 13'h000f;
  localparam logic [12:0] ADDR_COMMIT     = 13'h00ff;

  localparam int          CFG_COUNT       = 8;
  localparam int          CFG_IDX_W       = 3;

  localparam logic [7:0]  PORT_SETUP_RESET = 8'h18;
  localparam logic [7:0]  PORT_FIXED_MASK  = 8'h99;
  localparam logic [7:0]  PORT_FIXED_VAL   = 8'h18;
  localparam logic [7:0]  PORT_LSB_MASK    = 8'h42;
  localparam int          BIT_LSB_HI       = 6;
  localparam int          BIT_LSB_LO       = 1;
  localparam int          BIT_RST_HI       = 5;
  localparam int          BIT_RST_LO       = 2;
  localparam int          BIT_COMMIT       = 0;
  localparam logic        COMMIT_RESET     = 1'b0;

  // Reset values of the buffered channel-function registers, lowest address first.
  localparam logic [7:0]  CFG_RESET [CFG_COUNT] =
    '{8'hf0, 8'h01, 8'h00, 8'h00, 8'h04, 8'h00, 8'h00, 8'h00};

  localparam int          INST_RW_BIT  = 15;
  localparam int          INST_W_HI    = 14;
  localparam int          INST_W_LO    = 13;
  localparam logic [1:0]  W_STREAM     = 2'b11;
  localparam logic [2:0]  BIT_CNT_LAST = 3'h7;

  typedef enum logic [1:0] {
    ST_INSTR_HI,
    ST_INSTR_LO,
    ST_DATA
  } ssc_state_t;

endpackage

// ---- rtl/ssc_if.sv ----
// Byte-level link between the serial shifter and the register core.
`timescale 1ns/1ps
interface ssc_if;
  logic       rx_valid;
  logic [7:0] rx_byte;
  logic       frame_abort;
  logic       frame_end;
  logic       tx_load;
  logic [7:0] tx_byte;
  logic       sdo_en;
  logic       lsb_first;

  modport link (
    output rx_valid,
    output rx_byte,
    output frame_abort,
    output frame_end,
    input  tx_load,
    input  tx_byte,
    input  sdo_en,
    input  lsb_first
  );

  modport core (
    input  rx_valid,
    input  rx_byte,
    input  frame_abort,
    input  frame_end,
    output tx_load,
    output tx_byte,
    output sdo_en,
    output lsb_first
  );
endinterface

// ---- rtl/ssc_link.sv ----
// Serial pin shifter: synchronises the port pins and moves whole bytes in and out.
`timescale 1ns/1ps
module ssc_link
  import ssc_pkg::*;
(
  input  wire logic i_ref_clk, // System clock.
  input  wire logic i_rst_n,   // Asynchronous reset, active low.
  input  wire logic i_sclk,    // Serial clock pin.
  input  wire logic i_cs_n,    // Chip select pin, active low.
  input  wire logic i_sdi,     // Serial data in pin.
  output logic      o_sdo,     // Serial data out.
  output logic      o_sdo_oe,  // Output enable for serial data out.
  ssc_if.link       bus        // Byte link to the core.
);

  logic [2:0] sclk_q;
  logic [2:0] cs_q;
  logic [1:0] sdi_q;
  logic [2:0] bit_cnt;
  logic [7:0] sh_in;
  logic [7:0] next_in;
  logic [7:0] tx_sh;
  logic       sclk_rise;
  logic       sclk_fall;
  logic       cs_active;
  logic       cs_rise;

  // Stage 0 feeds only stage 1; edges are found between stages 1 and 2.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sclk_q <= 3'h0;
      cs_q   <= 3'h7;
      sdi_q  <= 2'h0;
    end
    else
    begin
      sclk_q <= {sclk_q[1:0], i_sclk};
      cs_q   <= {cs_q[1:0], i_cs_n};
      sdi_q  <= {sdi_q[0], i_sdi};
    end
  end

  assign sclk_rise = sclk_q[1] & ~sclk_q[2];
  assign sclk_fall = ~sclk_q[1] & sclk_q[2];
  assign cs_active = ~cs_q[1];
  assign cs_rise   = cs_q[1] & ~cs_q[2];
  assign next_in   = bus.lsb_first ? {sdi_q[1], sh_in[7:1]} : {sh_in[6:0], sdi_q[1]};

  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      bit_cnt     <= 3'h0;
      sh_in       <= 8'h00;
      bus.rx_valid    <= 1'b0;
      bus.rx_byte     <= 8'h00;
      bus.frame_abort <= 1'b0;
      bus.frame_end   <= 1'b0;
    end
    else
    begin
      bus.rx_valid    <= 1'b0;
      bus.frame_abort <= cs_rise && (bit_cnt != 3'h0);
      bus.frame_end   <= cs_rise && (bit_cnt == 3'h0);
      if (!cs_active)
      begin
        bit_cnt <= 3'h0;
      end
      else if (sclk_rise)
      begin
        sh_in   <= next_in;
        bit_cnt <= bit_cnt + 3'h1;
        if (bit_cnt == BIT_CNT_LAST)
        begin
          bus.rx_valid <= 1'b1;
          bus.rx_byte  <= next_in;
        end
      end
    end
  end

  // Read data leaves on falling edges so the host can sample it on the next rising edge.
  always_ff @(posedge i_ref_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      tx_sh    <= 8'h00;
      o_sdo    <= 1'b0;
      o_sdo_oe <= 1'b0;
    end
    else
    begin
      o_sdo_oe <= cs_active && bus.sdo_en;
      if (bus.tx_load)
      begin
        tx_sh <= bus.tx_byte;
      end
      else if (sclk_fall && cs_active && bus.sdo_en)
      begin
        o_sdo <= bus.lsb_first ? tx_sh[0] : tx_sh[7];
        tx_sh <= bus.lsb_first ? {1'b0, tx_sh[7:1]} : {tx_sh[6:0], 1'b0};
      end
    end
  end

endmodule

// ---- test/ssc_host_model.sv ----
// Serial host model that frames instructions and data on the control port pins.
`timescale 1ns/1ps
module ssc_host_model
(
  output logic      o_sclk,   // Serial clock, held low outside frames.
  output logic      o_cs_n,   // Chip select, active low.
  output logic      o_sdi,    // Serial data to the device.
  input  wire logic i_sdo,    // Serial data from the device.
  input  wire logic i_sdo_oe  // High while the device drives data out.
);
  logic [7:0] rd_data;
  event       rd_done;
  // A released data line shows the inverse of stored bit 0 of rd_data, so reading it is caught.
  wire        sdo_line = i_sdo_oe ? i_sdo : ~rd_data[0];

  initial
  begin
    o_sclk  = 1'b0;
    o_cs_n  = 1'b1;
    o_sdi   = 1'b0;
    rd_data = 8'h00;
  end

  // One instruction with a single data byte; 80 ns phases give a 160 ns link period.
  task automatic frame(input logic rd, input logic [12:0] addr, input logic [7:0] data,
                       input logic lsb);
    logic [15:0] instr;
    instr  = {rd, 2'b00, addr};
    o_cs_n = 1'b0;
    #80;
    for (int i = 0; i < 24; i++)
    begin
      // In LSB-first mode the whole instruction word goes out lowest bit first.
      o_sdi = (i < 16) ? instr[lsb ? i : 15 - i] : data[lsb ? i - 16 : 23 - i];
      #80;
      o_sclk = 1'b1;
      if (i >= 16)
        rd_data[lsb ? i - 16 : 23 - i] = sdo_line;
      #80;
      o_sclk = 1'b0;
    end
    #80;
    o_cs_n = 1'b1;
    o_sdi  = ~o_sdi;
    #320;
    if (rd)
      -> rd_done;
  endtask

  // A frame cut after a few bits, so that chip select rises in the middle of a byte.
  task automatic cut(input int bits);
    o_cs_n = 1'b0;
    #80;
    for (int i = 0; i < bits; i++)
    begin
      o_sdi = ~o_sdi;
      #80;
      o_sclk = 1'b1;
      #80;
      o_sclk = 1'b0;
    end
    #80;
    o_cs_n = 1'b1;
    #320;
  endtask
endmodule

// ---- test/tb_spi_config_register_core.sv ----
// Self-checking testbench for the serial configuration register core.
`timescale 1ns/1ps
module tb_spi_config_register_core;
  import ssc_pkg::*;
  localparam logic [7:0] ID = 8'h3c; // Arbitrary identifier value.

  logic                   i_ref_clk;
  logic                   i_rst_n;
  logic                   sclk;
  logic                   cs_n;
  logic                   sdi;
  logic                   sdo;
  logic                   sdo_oe;
  logic                   lsb;
  logic                   srst;
  logic [CFG_COUNT*8-1:0] act;
  logic [CFG_COUNT*8-1:0] exp_act;
  logic [7:0]             exp_q [$];
  logic [7:0]             r;
  int                     failures;
  int                     samples_checked;
  int                     cycles;
  int                     pulses;

  ssc_core #(.P_PART_ID(ID)) uut
  (
    .i_ref_clk    (i_ref_clk),
    .i_rst_n      (i_rst_n),
    .i_sclk       (sclk),
    .i_cs_n       (cs_n),
    .i_sdi        (sdi),
    .o_sdo        (sdo),
    .o_sdo_oe     (sdo_oe),
    .o_lsb_first  (lsb),
    .o_soft_reset (srst),
    .o_active_cfg (act)
  );

  ssc_host_model host
  (
    .o_sclk   (sclk),
    .o_cs_n   (cs_n),
    .o_sdi    (sdi),
    .i_sdo    (sdo),
    .i_sdo_oe (sdo_oe)
  );

  initial
    i_ref_clk = 1'b0;
  always #10 i_ref_clk = ~i_ref_clk;

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  function automatic logic [63:0] cfg_default();
    logic [63:0] v;
    for (int g = 0; g < CFG_COUNT; g++)
      v[g*8 +: 8] = CFG_RESET[g];
    return v;
  endfunction

  // The expected byte is queued before the frame; the watcher compares when it ends.
  task automatic rd(input logic [12:0] a, input logic [7:0] e, input logic l);
    exp_q.push_back(e);
    host.frame(1'b1, a, 8'h00, l);
  endtask

  task automatic wr(input logic [12:0] a, input logic [7:0] d, input logic l);
    host.frame(1'b0, a, d, l);
  endtask

  always @(host.rd_done)
    check("read data", 64'(host.rd_data), 64'(exp_q.pop_front()));

  // Counts soft reset pulses on the falling edge, where the pulse has settled.
  // It also cuts a hang short.
  always @(negedge i_ref_clk)
  begin
    cycles++;
    if (srst === 1'b1)
      pulses++;
    if (cycles == 20000)
    begin
      failures++;
      $display("BAD run time limit reached");
      complete_run();
    end
  end

  initial
  begin
    i_rst_n         = 1'b0;
    failures        = 0;
    samples_checked = 0;
    cycles          = 0;
    pulses          = 0;
    void'($urandom(77));
    repeat (3) @(posedge i_ref_clk);
    #2;
    i_rst_n = 1'b1;
    repeat (4) @(posedge i_ref_clk);
    #2;
    check("active after reset", act, cfg_default());
    check("order after reset", 64'(lsb), 64'h0);
    rd(ADDR_PORT_SETUP, PORT_SETUP_RESET, 1'b0);
    rd(ADDR_PART_ID, ID, 1'b0);
    rd(ADDR_COMMIT, 8'h00, 1'b0);
    r = 8'($urandom);
    wr(ADDR_PART_ID, r, 1'b0);
    rd(ADDR_PART_ID, ID, 1'b0);
    // Bits 7 and 0 have no function; 4 and 3 are fixed.
    wr(ADDR_PORT_SETUP, 8'h99, 1'b0);
    rd(ADDR_PORT_SETUP, PORT_SETUP_RESET, 1'b0);
    check("order after undefined bits", 64'(lsb), 64'h0);
    exp_act = cfg_default();
    for (int g = 0; g < CFG_COUNT; g++)
    begin
      r = 8'($urandom);
      exp_act[g*8 +: 8] = r;
      wr(ADDR_CFG_FIRST + 13'(g), r, 1'b0);
    end
    check("active before commit", act, cfg_default());
    wr(ADDR_COMMIT, 8'hfe, 1'b0);
    check("active after empty commit", act, cfg_default());
    wr(ADDR_COMMIT, 8'h01, 1'b0);
    check("active after commit", act, exp_act);
    rd(ADDR_COMMIT, 8'h00, 1'b0);
    for (int g = 0; g < CFG_COUNT; g++)
      rd(ADDR_CFG_FIRST + 13'(g), exp_act[g*8 +: 8], 1'b0);
    // Mirrored nibbles select lowest bit first.
    wr(ADDR_PORT_SETUP, 8'h5a, 1'b0);
    check("order after setup", 64'(lsb), 64'h1);
    rd(ADDR_PORT_SETUP, 8'h5a, 1'b1);
    wr(ADDR_CFG_FIRST, 8'ha5, 1'b1);
    rd(ADDR_CFG_FIRST, 8'ha5, 1'b1);
    pulses = 0;
    wr(ADDR_PORT_SETUP, 8'h3c, 1'b1);
    check("soft reset pulses", 64'(pulses), 64'h1);
    check("order after soft reset", 64'(lsb), 64'h0);
    check("active after soft reset", act, cfg_default());
    rd(ADDR_PORT_SETUP, PORT_SETUP_RESET, 1'b0);
    rd(ADDR_CFG_FIRST, CFG_RESET[0], 1'b0);
    // A frame cut mid-byte is dropped; the next instruction must still be understood.
    host.cut(9 + int'($urandom % 7));
    rd(ADDR_PART_ID, ID, 1'b0);
    // Leave non-default state behind, then pull the reset pin in mid-run.
    r = 8'($urandom);
    wr(ADDR_PORT_SETUP, 8'h5a, 1'b0);
    wr(ADDR_CFG_LAST, r, 1'b1);
    wr(ADDR_COMMIT, 8'h01, 1'b1);
    exp_act = cfg_default();
    exp_act[(CFG_COUNT-1)*8 +: 8] = r;
    check("active before reset", act, exp_act);
    check("order before reset", 64'(lsb), 64'h1);
    i_rst_n = 1'b0;
    repeat (3) @(posedge i_ref_clk);
    #2;
    i_rst_n = 1'b1;
    repeat (4) @(posedge i_ref_clk);
    #2;
    check("active after mid-run reset", act, cfg_default());
    check("order after mid-run reset", 64'(lsb), 64'h0);
    rd(ADDR_CFG_LAST, CFG_RESET[CFG_COUNT-1], 1'b0);
    rd(ADDR_PORT_SETUP, PORT_SETUP_RESET, 1'b0);
    // The last read is compared by the watcher; let it run before the verdict.
    wait (exp_q.size() == 0);
    @(posedge i_ref_clk);
    complete_run();
  end
endmodule
